// ===== pkg/icl_params.svh
// Constants of the instruction cache: geometry, address fields, reset values
`ifndef ICL_PARAMS_SVH
`define ICL_PARAMS_SVH
`define ICL_SEGS 4
`define ICL_SUBS 8
`define ICL_LWS 4
`define ICL_TAG_W 22
`define ICL_TAG_LSB 10
`define ICL_SUB_LSB 7
`define ICL_LW_LSB 5
`define ICL_HALF_BIT 4
`define ICL_LW_STEP 32'h0000_0020
`define ICL_LAST_LW 2'h3
`define ICL_RST_ADDR 32'h0000_0000
`define ICL_RST_WORD 16'h0000
`endif

// ===== pkg/icl_pkg.sv
// Types shared by the instruction cache and its replacement stack
`include "icl_params.svh"
package icl_pkg;
  typedef logic [1:0] icl_seg_t;
  typedef logic [2:0] icl_sub_t;
  typedef logic [1:0] icl_lw_t;
  typedef logic [`ICL_TAG_W-1:0] icl_tag_t;
  typedef enum logic [1:0] {
    ICL_IDLE = 2'h0,
    ICL_LOOK = 2'h1,
    ICL_FILL = 2'h3
  } icl_state_t;
  typedef struct packed {
    icl_state_t state;
    logic [31:0] addr;
    logic [`ICL_SEGS-1:0][`ICL_SUBS-1:0][`ICL_LWS-1:0][31:0] data;
    logic [`ICL_SEGS-1:0][`ICL_SUBS-1:0] valid;
    icl_tag_t [`ICL_SEGS-1:0] tag;
    icl_seg_t fill_seg;
    icl_lw_t lw_cnt;
    logic flushed;
    logic fetch_ack;
    logic [15:0] fetch_data;
    logic mem_req;
    logic [31:0] mem_addr;
  } icl_state_reg_t;
  typedef struct packed {
    icl_seg_t [`ICL_SEGS-1:0] stack;
  } icl_lru_reg_t;
endpackage

// ===== pkg/icl_lru_if.sv
// Link between the cache controller and its usage-order stack
`timescale 1ns/1ns
`default_nettype none
interface icl_lru_if;
  import icl_pkg::*;
  logic touch;
  icl_seg_t touch_seg;
  icl_seg_t victim;
  modport cache (output touch, output touch_seg, input victim);
  modport lru (input touch, input touch_seg, output victim);
endinterface
`default_nettype wire

// ===== core/icl_lru.sv
// Four-entry usage-order stack that names the least recently used segment
`timescale 1ns/1ns
`default_nettype none
`include "icl_params.svh"
module icl_lru
  import icl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  icl_lru_if.lru lif
);
  icl_lru_reg_t r;
  icl_lru_reg_t next_r;
  logic found;

  // Move the touched segment to the top, shift the younger ones down
  always_comb begin
    next_r = r;
    found = 1'b0;
    if (lif.touch) begin
      for (int i = `ICL_SEGS - 1; i > 0; i--) begin
        if (r.stack[i] == lif.touch_seg) begin
          found = 1'b1;
        end
        if (found) begin
          next_r.stack[i] = r.stack[i-1];
        end
      end
      next_r.stack[0] = lif.touch_seg;
    end
    if (!resetn) begin
      for (int i = 0; i < `ICL_SEGS; i++) begin
        next_r.stack[i] = icl_seg_t'(i);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    r <= next_r;
  end

  // Bottom of the stack is the replacement choice
  assign lif.victim = r.stack[`ICL_SEGS-1];

  AST_LRU_TOUCH_TOP: assert property (@(posedge ref_clk) disable iff (!resetn)
    lif.touch |=> r.stack[0] == $past(lif.touch_seg))
    else $error("touched segment not on top of stack");
  AST_LRU_NOT_VICTIM: assert property (@(posedge ref_clk) disable iff (!resetn)
    lif.touch |=> lif.victim != $past(lif.touch_seg))
    else $error("just used segment chosen for replacement");
endmodule // icl_lru
`default_nettype wire

// ===== core/icl_cache.sv
// Instruction cache: four segments, subsegment fill from memory, LRU replacement
`timescale 1ns/1ns
`default_nettype none
`include "icl_params.svh"
module icl_cache
  import icl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  output logic fetch_ack,
  output logic [15:0] fetch_data,
  input wire logic flush_req,
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_data
);
  icl_state_reg_t r;
  icl_state_reg_t next_r;
  icl_lru_if lif ();
  logic seg_hit;
  icl_seg_t seg_idx;
  logic hit;
  logic [31:0] hit_lw;

  // Address field helpers; bits 3:0 never take part
  function automatic icl_tag_t tag_of(input logic [31:0] a);
    return a[31:`ICL_TAG_LSB];
  endfunction
  function automatic icl_sub_t sub_of(input logic [31:0] a);
    return a[`ICL_TAG_LSB-1:`ICL_SUB_LSB];
  endfunction
  function automatic icl_lw_t lw_of(input logic [31:0] a);
    return a[`ICL_SUB_LSB-1:`ICL_LW_LSB];
  endfunction

  icl_lru u_lru (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .lif(lif)
  );

  // Tag compare; a segment with no valid flag never matches
  always_comb begin
    seg_hit = 1'b0;
    seg_idx = '0;
    for (int i = 0; i < `ICL_SEGS; i++) begin
      if (r.tag[i] == tag_of(r.addr) && |r.valid[i]) begin
        seg_hit = 1'b1;
        seg_idx = icl_seg_t'(i);
      end
    end
    hit = seg_hit && r.valid[seg_idx][sub_of(r.addr)];
    hit_lw = r.data[seg_idx][sub_of(r.addr)][lw_of(r.addr)];
  end

  // Every lookup, hit or allocation, makes that segment most recent
  assign lif.touch = (r.state == ICL_LOOK);
  assign lif.touch_seg = seg_hit ? seg_idx : lif.victim;

  // Controller: lookup, fill, flush and reset all in one next-state copy
  always_comb begin
    next_r = r;
    next_r.fetch_ack = 1'b0;
    unique case (r.state)
      ICL_IDLE: begin
        if (fetch_req) begin
          next_r.addr = fetch_addr;
          next_r.state = ICL_LOOK;
        end
      end
      ICL_LOOK: begin
        if (hit) begin
          // Low half word first within a long word
          next_r.fetch_data = r.addr[`ICL_HALF_BIT] ? hit_lw[31:16] : hit_lw[15:0];
          next_r.fetch_ack = 1'b1;
          next_r.state = ICL_IDLE;
        end else begin
          if (!seg_hit) begin
            next_r.valid[lif.victim] = '0;
            next_r.tag[lif.victim] = tag_of(r.addr);
          end
          next_r.fill_seg = seg_hit ? seg_idx : lif.victim;
          next_r.lw_cnt = '0;
          next_r.flushed = 1'b0;
          next_r.mem_req = 1'b1;
          next_r.mem_addr = {r.addr[31:`ICL_SUB_LSB], 7'h00};
          next_r.state = ICL_FILL;
        end
      end
      ICL_FILL: begin
        if (mem_ack) begin
          next_r.data[r.fill_seg][sub_of(r.addr)][r.lw_cnt] = mem_data;
          next_r.lw_cnt = r.lw_cnt + 2'h1;
          next_r.mem_addr = r.mem_addr + `ICL_LW_STEP;
          if (r.lw_cnt == `ICL_LAST_LW) begin
            next_r.mem_req = 1'b0;
            next_r.mem_addr = r.mem_addr;
            // A flush during the fill discards it: data may predate the flush
            if (!r.flushed && !flush_req) begin
              next_r.valid[r.fill_seg][sub_of(r.addr)] = 1'b1;
            end
            next_r.state = ICL_LOOK;
          end
        end
      end
      // Unused code: fall back to idle rather than hang
      default: begin
        next_r.state = ICL_IDLE;
      end
    endcase
    // Flush wins over a completing fill to keep results exact
    if (flush_req) begin
      next_r.valid = '0;
      next_r.flushed = 1'b1;
    end
    // Tags and data are left alone by reset
    if (!resetn) begin
      next_r.state = ICL_IDLE;
      next_r.valid = '0;
      next_r.flushed = 1'b0;
      next_r.lw_cnt = '0;
      next_r.fetch_ack = 1'b0;
      next_r.fetch_data = `ICL_RST_WORD;
      next_r.mem_req = 1'b0;
      next_r.mem_addr = `ICL_RST_ADDR;
      next_r.addr = `ICL_RST_ADDR;
    end
  end

  always_ff @(posedge ref_clk) begin
    r <= next_r;
  end

  assign fetch_ack = r.fetch_ack;
  assign fetch_data = r.fetch_data;
  assign mem_req = r.mem_req;
  assign mem_addr = r.mem_addr;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  AST_HIT_NO_FETCH: assert property (r.state == ICL_LOOK && hit |=> !mem_req && fetch_ack)
    else $error("hit started a memory read");
  AST_MISS_FETCH: assert property (r.state == ICL_LOOK && !hit |=> mem_req && !fetch_ack)
    else $error("miss did not request memory");
  AST_FILL_ENDS: assert property (mem_req && mem_ack && r.lw_cnt == 2'h3 |=> !mem_req)
    else $error("fill did not stop after four long words");
  AST_FILL_ADDR: assert property (mem_req |-> mem_addr[4:0] == 5'h00)
    else $error("memory address not long-word aligned");
  AST_FLUSH_CLEARS: assert property (flush_req |=> r.valid == '0)
    else $error("flush left a valid subsegment");
  AST_RESET_CLEARS: assert property ($rose(resetn) |-> r.valid == '0 && !mem_req)
    else $error("valid flags survived reset");
  AST_VICTIM_CLEARED: assert property (r.state == ICL_LOOK && !seg_hit
    |=> r.valid[$past(lif.victim)] == '0 && r.tag[$past(lif.victim)] == $past(tag_of(r.addr)))
    else $error("replaced segment kept old flags or tag");
  AST_ACK_AFTER_FILL: assert property (r.state == ICL_FILL && mem_ack && r.lw_cnt == 2'h3
    && !flush_req && !r.flushed |=> ##1 fetch_ack)
    else $error("fetcher not answered after fill");

  // An answer is a single-cycle strobe; the fetcher must not take it twice
  AST_ACK_PULSE: assert property (fetch_ack |=> !fetch_ack)
    else $error("fetch answer held longer than one cycle");

  // The word stays put between answers, so a slow reader still sees it
  AST_DATA_HOLDS: assert property (!fetch_ack && $past(resetn)
    |-> $stable(fetch_data))
    else $error("instruction word changed without an answer");

  // Memory is only ever busy for a fill
  AST_MEM_ONLY_FILL: assert property (r.state != ICL_FILL |-> !mem_req)
    else $error("memory read outside a fill");

  // The fetcher stays stalled for the whole fill
  AST_NO_ACK_IN_FILL: assert property (r.state == ICL_FILL |-> !fetch_ack)
    else $error("fetcher answered during a fill");

  // Between answers from memory the requested address must not move
  AST_FILL_ADDR_HOLD: assert property (mem_req && !mem_ack |=> $stable(mem_addr))
    else $error("memory address moved while waiting");

  // Each long word follows the last at the next long-word address
  AST_FILL_ADDR_STEP: assert property (mem_req && mem_ack && r.lw_cnt != `ICL_LAST_LW
    |=> mem_addr == $past(mem_addr) + `ICL_LW_STEP)
    else $error("memory address did not step by one long word");

  // A fill always starts at long word 0 of the missed subsegment
  AST_FILL_BASE: assert property (r.state == ICL_LOOK && !hit
    |=> mem_addr == {$past(r.addr[31:`ICL_SUB_LSB]), 7'h00})
    else $error("fill started at the wrong address");

  // A finished fill marks exactly one more subsegment valid
  AST_ONE_SUB_FILLED: assert property (r.state == ICL_FILL && mem_ack
    && r.lw_cnt == `ICL_LAST_LW && !flush_req && !r.flushed
    |=> $countones(r.valid) == $countones($past(r.valid)) + 1)
    else $error("fill did not mark exactly one subsegment");

  // A hit only reads; no flag moves unless the host flushes
  AST_HIT_KEEPS_FLAGS: assert property (r.state == ICL_LOOK && hit && !flush_req
    |=> r.valid == $past(r.valid))
    else $error("hit changed a valid flag");

  // The segment being filled already carries the tag of the miss
  AST_FILL_TAGGED: assert property (r.state == ICL_FILL
    |-> r.tag[r.fill_seg] == tag_of(r.addr))
    else $error("fill target carries a foreign tag");
endmodule // icl_cache
`default_nettype wire

// ===== sim/icl_mem_model.sv
// Local memory model that answers cache fills one long word at a time
`timescale 1ns/1ns
`default_nettype none
module icl_mem_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] lat,
  output logic mem_ack,
  output logic [31:0] mem_data,
  output var int words
);
  int wait_cnt;
  // Word after lat idle cycles; bus toggles between pulses so stale data never looks valid
  always @(posedge ref_clk) begin
    mem_ack <= 1'b0;
    mem_data <= ~mem_data;
    if (!resetn) begin
      wait_cnt <= 0;
    end else if (mem_req && !mem_ack) begin
      if (wait_cnt >= lat) begin
        mem_ack <= 1'b1;
        mem_data <= {mem_addr[20:5] ^ 16'hc3c3, mem_addr[20:5]};
        words <= words + 1;
        wait_cnt <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
  // Quiet bus at time zero
  initial begin
    mem_ack = 1'b0;
    mem_data = 32'h0000_0000;
    words = 0;
  end
endmodule // icl_mem_model
`default_nettype wire

// ===== sim/tb_instruction_cache_lru.sv
// Self-checking bench for the instruction cache
`timescale 1ns/1ns
`default_nettype none
module tb_instruction_cache_lru;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic fetch_req = 1'b0;
  logic flush_req = 1'b0;
  logic [31:0] fetch_addr = 32'h0000_0000;
  logic [3:0] lat = 4'h0;
  logic fetch_ack, mem_req, mem_ack;
  logic [15:0] fetch_data;
  logic [31:0] mem_addr, mem_data;
  int words;
  int errors = 0;
  int comparisons = 0;

  always #50 ref_clk = ~ref_clk;

  icl_cache i_dut (.ref_clk(ref_clk), .resetn(resetn), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
    .flush_req(flush_req), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_data(mem_data));
  icl_mem_model i_mem (.ref_clk(ref_clk), .resetn(resetn), .mem_req(mem_req),
    .mem_addr(mem_addr), .lat(lat), .mem_ack(mem_ack), .mem_data(mem_data), .words(words));

  task automatic check(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Fetch one word; fills < 0 skips the memory count, flush_at pulses a flush
  task automatic fetch(logic [31:0] a, int fills, int flush_at);
    int n;
    int w0;
    w0 = words;
    fetch_addr = a;
    fetch_req = 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
      flush_req = (n == flush_at) && (fetch_ack !== 1'b1);
    end while (n < 200 && fetch_ack !== 1'b1);
    fetch_req = 1'b0;
    check({31'h0, fetch_ack}, 32'h1);
    check({16'h0, fetch_data}, {16'h0, a[4] ? a[20:5] ^ 16'hc3c3 : a[20:5]});
    if (fills >= 0) check(words - w0, fills * 4);
    // A hit answers two edges after the request is raised
    if (fills == 0) check(n, 2);
    // One idle edge, so the next call never re-raises a strobe in this time step
    @(posedge ref_clk);
    #1;
  endtask

  task automatic flush;
    flush_req = 1'b1;
    @(posedge ref_clk);
    #1;
    flush_req = 1'b0;
  endtask

  // Subsegment fill and half-word selection
  task automatic t_fill;
    fetch(32'h0000_2000, 1, -1);
    fetch(32'h0000_206f, 0, -1);
    fetch(32'h0000_2090, 1, -1);
    fetch(32'h0000_2010, 0, -1);
  endtask

  // Replacement picks the oldest segment and wipes its flags
  task automatic t_lru;
    lat = 4'h2;
    flush();
    fetch(32'h0000_0000, 1, -1);
    fetch(32'h0000_0400, 1, -1);
    fetch(32'h0000_0480, 1, -1);
    fetch(32'h0000_0800, 1, -1);
    fetch(32'h0000_0c00, 1, -1);
    fetch(32'h0000_0010, 0, -1);
    fetch(32'h0000_1000, 1, -1);
    fetch(32'h0000_1080, 1, -1);
    fetch(32'h0000_0000, 0, -1);
    fetch(32'h0000_0800, 0, -1);
    fetch(32'h0000_0c00, 0, -1);
    fetch(32'h0000_0480, 1, -1);
  endtask

  // Flush when idle and in mid-fill
  task automatic t_flush;
    lat = 4'h4;
    fetch(32'h0000_0800, 0, -1);
    flush();
    fetch(32'h0000_0800, 1, -1);
    fetch(32'h0000_3000, 2, 3);
    fetch(32'h0000_3010, 0, -1);
  endtask

  // Reset in mid-fill drops the fill and all cached contents
  task automatic t_reset;
    lat = 4'h4;
    fetch_addr = 32'h0000_5000;
    fetch_req = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    check({31'h0, mem_req}, 32'h1);
    fetch_req = 1'b0;
    resetn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check({31'h0, mem_req}, 32'h0);
    check({31'h0, fetch_ack}, 32'h0);
    check({16'h0, fetch_data}, 32'h0);
    lat = 4'h0;
    resetn = 1'b1;
    fetch(32'h0000_0800, 1, -1);
    fetch(32'h0000_0810, 0, -1);
  endtask

  task automatic final_report;
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    t_fill();
    t_lru();
    t_flush();
    t_reset();
    final_report();
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #3000000;
    errors++;
    final_report();
  end
endmodule // tb_instruction_cache_lru
`default_nettype wire
